// >>> logic/mcid_decoder.sv
`include "mcid_consts.svh"
`default_nettype none
module mcid_decoder #(
  parameter int CMD_W   = `MCID_CMD_W,
  parameter int CNT_W   = `MCID_CNT_W,
  parameter int TIMEOUT = `MCID_PWM_PERIOD * `MCID_TIMEOUT_MULT
) (
  // clock and reset
  input  wire logic                    i_clock,
  input  wire logic                    i_rst,
  // configuration
  input  wire mcid_pkg::mcid_method_t  i_method,
  input  wire mcid_pkg::mcid_mode_t    i_mode,
  // host command lines
  input  wire logic                    i_enable,
  input  wire logic                    i_direction,
  input  wire logic                    i_pwm,
  input  wire logic [CMD_W-1:0]        i_analog_level,
  // decoded command
  output logic signed [CMD_W:0]        o_speed_cmd,
  output logic                         o_run,
  output logic                         o_coast,
  output logic                         o_preset_run,
  output logic                         o_config_error
);
  localparam logic [CMD_W-1:0] CMD_MAX = {CMD_W{1'b1}};

  mcid_duty_if #(.CNT_W(CNT_W)) duty ();

  logic              pwm_src;
  logic [CMD_W-1:0]  mag_pwm;
  logic [CMD_W-1:0]  signed_mag;
  logic              signed_cw;
  logic [CMD_W-1:0]  held_mag;
  logic              held_cw;
  logic              method_ok;
  logic signed [CMD_W:0] next_speed_cmd;

  // scale high time over period to the command range
  function automatic logic [CMD_W-1:0] mcid_scale(input logic [CNT_W-1:0] hi,
                                                   input logic [CNT_W-1:0] per);
    logic [CNT_W+CMD_W-1:0] prod;
    prod = '0;
    if (per == '0 || hi >= per) begin
      mcid_scale = CMD_MAX;
    end else begin
      prod       = (CNT_W+CMD_W)'(hi) * (CNT_W+CMD_W)'(CMD_MAX);
      mcid_scale = CMD_W'(prod / (CNT_W+CMD_W)'(per));
    end
  endfunction : mcid_scale

  // apply a sense to a magnitude
  function automatic logic signed [CMD_W:0] mcid_sign(input logic [CMD_W-1:0] mag, input logic cw);
    mcid_sign = cw ? $signed({1'b0, mag}) : -$signed({1'b0, mag});
  endfunction : mcid_sign

  // combined method reads its pwm from the direction line
  assign pwm_src = (i_method == mcid_pkg::MCID_PWM_DIR) ? i_direction : i_pwm;

  mcid_duty_meter #(.CNT_W(CNT_W), .TIMEOUT(TIMEOUT)) u_meter (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_pwm   (pwm_src),
    .duty    (duty)
  );

  // magnitude; a line held constant reads as 0% or 100%
  assign mag_pwm = duty.stale ? (pwm_src ? CMD_MAX : '0)
                              : mcid_scale(duty.high_cnt, duty.period_cnt);

  // combined method: 50% gives -1 (magnitude never drops below 1), 0% full ccw, 100% full cw
  always_comb begin
    signed_cw  = mag_pwm[CMD_W-1];
    signed_mag = signed_cw ? CMD_W'({mag_pwm[CMD_W-2:0], 1'b1})
                           : CMD_W'({~mag_pwm[CMD_W-2:0], 1'b1});
  end

  // latch pwm results once per completed period and on every cycle while stale
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      held_mag <= '0;
      held_cw  <= 1'b1;
    end else if (duty.done || duty.stale) begin
      held_mag <= (i_method == mcid_pkg::MCID_PWM_DIR) ? signed_mag : mag_pwm;
      held_cw  <= signed_cw;
    end
  end

  // enable-only method valid only with preset speed
  assign method_ok = (i_method != mcid_pkg::MCID_ON_OFF) || (i_mode == mcid_pkg::MCID_PRESET_SPEED);

  // command selection per method
  always_comb begin
    next_speed_cmd = '0;
    case (i_method)
      mcid_pkg::MCID_ANALOG:  next_speed_cmd = mcid_sign(i_analog_level, i_direction);
      mcid_pkg::MCID_PWM:     next_speed_cmd = mcid_sign(held_mag, i_direction);
      mcid_pkg::MCID_PWM_DIR: next_speed_cmd = mcid_sign(held_mag, held_cw);
      mcid_pkg::MCID_ON_OFF:  next_speed_cmd = '0;
      default:                next_speed_cmd = '0;
    endcase
    if (!i_enable || !method_ok) next_speed_cmd = '0;
  end

  // speed command follows the selected method one edge later
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_speed_cmd <= '0;
    end else begin
      o_speed_cmd <= next_speed_cmd;
    end
  end

  // run permit; only a legal method may drive the windings
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_run <= 1'b0;
    end else begin
      o_run <= i_enable && method_ok;
    end
  end

  // coast whenever run is withheld so windings float rather than brake
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_coast <= 1'b1;
    end else begin
      o_coast <= !(i_enable && method_ok);
    end
  end

  // preset request; the fixed speed itself is applied further down the drive
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_preset_run <= 1'b0;
    end else begin
      o_preset_run <= i_enable && (i_mode == mcid_pkg::MCID_PRESET_SPEED);
    end
  end

  // flags enable-only without preset for as long as that pairing stands
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_config_error <= 1'b0;
    end else begin
      o_config_error <= !method_ok;
    end
  end
endmodule : mcid_decoder
`default_nettype wire

// >>> common/mcid_consts.svh
// Overview of operation
// - analog level maps linearly, zero to maximum
// - run-permit high starts driving the motor
// - run-permit low releases windings, motor coasts
// - analog method: direction high means clockwise
// - pwm duty 0..100% maps to min..max
// - combined method reads pwm from direction line
// - combined 0% duty: full counterclockwise
// - combined 100% duty: full clockwise
// - combined 50% duty: zero command; the code gives -1, as its magnitude is never below 1
// - enable-only method requires preset speed mode
`ifndef MCID_CONSTS_SVH
`define MCID_CONSTS_SVH
`define MCID_CLK_HZ        40000000
`define MCID_PWM_HZ        2500
`define MCID_PWM_PERIOD    (`MCID_CLK_HZ / `MCID_PWM_HZ)
`define MCID_TIMEOUT_MULT  4
`define MCID_CNT_W         16
`define MCID_CMD_W         12
`endif

// >>> common/mcid_pkg.sv
`default_nettype none
package mcid_pkg;
  // control methods selected by configuration
  typedef enum logic [1:0] {
    MCID_ANALOG,
    MCID_PWM,
    MCID_PWM_DIR,
    MCID_ON_OFF
  } mcid_method_t;
  // operating modes
  typedef enum logic [1:0] {
    MCID_OPEN_SPEED,
    MCID_CLOSED_SPEED,
    MCID_PRESET_SPEED,
    MCID_TORQUE
  } mcid_mode_t;
endpackage : mcid_pkg
`default_nettype wire

// >>> common/mcid_duty_if.sv
`default_nettype none
// carries one measured period from the meter to the decoder
interface mcid_duty_if #(parameter int CNT_W = 16) ();
  logic             done;
  logic [CNT_W-1:0] high_cnt;
  logic [CNT_W-1:0] period_cnt;
  logic             stale;
  modport meter (output done, output high_cnt, output period_cnt, output stale);
  modport user  (input  done, input  high_cnt, input  period_cnt, input  stale);
endinterface : mcid_duty_if
`default_nettype wire

// >>> logic/mcid_duty_meter.sv
`include "mcid_consts.svh"
`default_nettype none
module mcid_duty_meter #(
  parameter int CNT_W   = `MCID_CNT_W,
  parameter int TIMEOUT = `MCID_PWM_PERIOD * `MCID_TIMEOUT_MULT
) (
  // clock and reset
  input  wire logic   i_clock,
  input  wire logic   i_rst,
  // pwm sample
  input  wire logic   i_pwm,
  // measurement out
  mcid_duty_if.meter  duty
);
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
  localparam logic [CNT_W-1:0] TO_CNT  = CNT_W'(TIMEOUT);

  logic             pwm_d;
  logic             primed;
  logic             started;
  logic [CNT_W-1:0] hi;
  logic [CNT_W-1:0] per;
  logic             rise;

  // no edge is seen until the history holds a real sample, so a line idling high
  // cannot fake a rise on the first edge after reset
  assign rise = i_pwm & ~pwm_d & primed;

  // edge history
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pwm_d  <= 1'b0;
      primed <= 1'b0;
    end else begin
      pwm_d  <= i_pwm;
      primed <= 1'b1;
    end
  end

  // count high time and period between rising edges; saturate so a stuck line cannot wrap
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      hi              <= '0;
      per             <= '0;
      started         <= 1'b0;
      duty.done       <= 1'b0;
      duty.high_cnt   <= '0;
      duty.period_cnt <= '0;
    end else begin
      duty.done <= 1'b0;
      if (rise) begin
        if (started) begin
          duty.done       <= 1'b1;
          duty.high_cnt   <= hi;
          duty.period_cnt <= per;
        end
        started <= 1'b1;
        hi      <= CNT_W'(1); // the rising-edge cycle counts as high
        per     <= CNT_W'(1);
      end else begin
        if (per != CNT_MAX) per <= per + CNT_W'(1);
        if (i_pwm && hi != CNT_MAX) hi <= hi + CNT_W'(1);
      end
    end
  end

  // no edge for too long: line is held at a constant level (0% or 100%)
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      duty.stale <= 1'b1;
    end else if (rise) begin
      duty.stale <= 1'b0;
    end else if (per >= TO_CNT) begin
      duty.stale <= 1'b1;
    end
  end
endmodule : mcid_duty_meter
`default_nettype wire

// >>> tb/mcid_chk_properties.sv
`default_nettype none
module mcid_chk #(parameter int CMD_W = 12) (
  // watched pins
  input wire logic i_clock,
  input wire logic i_rst,
  input wire mcid_pkg::mcid_method_t i_method,
  input wire mcid_pkg::mcid_mode_t i_mode,
  input wire logic i_enable,
  input wire logic i_direction,
  input wire logic [CMD_W-1:0] i_analog_level,
  input wire logic signed [CMD_W:0] o_speed_cmd,
  input wire logic o_run,
  input wire logic o_coast,
  input wire logic o_preset_run,
  input wire logic o_config_error
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // on/off outside preset mode must be refused
  sequence s_bad;
    i_method == mcid_pkg::MCID_ON_OFF && i_mode != mcid_pkg::MCID_PRESET_SPEED;
  endsequence
  property p_run; i_enable && i_method != mcid_pkg::MCID_ON_OFF |=> o_run; endproperty
  a_run: assert property (p_run) else $error("run not raised");
  property p_coast; !i_enable |=> !o_run && o_coast && !o_preset_run; endproperty
  a_coast: assert property (p_coast) else $error("no coast");
  property p_inv; o_coast == !o_run; endproperty
  a_inv: assert property (p_inv) else $error("coast and run disagree");
  property p_ana; i_enable && i_method == mcid_pkg::MCID_ANALOG |=> o_speed_cmd == ($past(i_direction) ?
    $signed({1'b0, $past(i_analog_level)}) : -$signed({1'b0, $past(i_analog_level)})); endproperty
  a_ana: assert property (p_ana) else $error("analog command wrong");
  property p_pre; i_enable && i_mode == mcid_pkg::MCID_PRESET_SPEED |=> o_preset_run; endproperty
  a_pre: assert property (p_pre) else $error("preset run missing");
  property p_err; s_bad |=> o_config_error && !o_run; endproperty
  a_err: assert property (p_err) else $error("bad config accepted");
  property p_ok; i_method != mcid_pkg::MCID_ON_OFF |=> !o_config_error; endproperty
  a_ok: assert property (p_ok) else $error("false config error");
  property p_oo; i_enable && i_method == mcid_pkg::MCID_ON_OFF && i_mode == mcid_pkg::MCID_PRESET_SPEED
    |=> o_run && o_speed_cmd == 0; endproperty
  a_oo: assert property (p_oo) else $error("on/off run wrong");
endmodule : mcid_chk
bind mcid_decoder mcid_chk #(.CMD_W(CMD_W)) u_chk (.i_clock, .i_rst, .i_method, .i_mode, .i_enable,
  .i_direction, .i_analog_level, .o_speed_cmd, .o_run, .o_coast, .o_preset_run, .o_config_error);
`default_nettype wire

// >>> tb/mcid_host_model.sv
`default_nettype none
module mcid_host_model (
  // clock
  input wire logic i_clock,
  // high and period in cycles
  input wire logic [15:0] i_high,
  input wire logic [15:0] i_period,
  // command line
  output logic o_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt = '0;
  // fixed period, only the high time moves; active high
  always @(negedge i_clock) begin
    cnt <= (cnt + 16'h1 >= i_period) ? 16'h0 : cnt + 16'h1;
    o_line <= cnt < i_high;
  end
endmodule : mcid_host_model
`default_nettype wire

// >>> tb/mcid_decoder_tb.sv
`default_nettype none
module mcid_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 0, i_rst = 1, i_enable = 0, i_dir = 0, line, run, coast, prun, cerr;
  mcid_pkg::mcid_method_t i_method = mcid_pkg::MCID_ANALOG;
  mcid_pkg::mcid_mode_t i_mode = mcid_pkg::MCID_OPEN_SPEED;
  logic [11:0] lvl = '0;
  logic [15:0] hi = '0;
  logic signed [12:0] cmd;
  int err_total = 0, comparisons = 0, cyc = 0;
  // host drives the line at a scaled-down 100 cycle period
  mcid_host_model u_host (.i_clock, .i_high(hi), .i_period(16'h64), .o_line(line));
  // short timeout keeps the stale case quick
  mcid_decoder #(.TIMEOUT(200)) u_dut (.i_clock, .i_rst, .i_method, .i_mode, .i_enable,
    .i_direction(i_method == mcid_pkg::MCID_PWM_DIR ? line : i_dir),
    .i_pwm(i_method == mcid_pkg::MCID_PWM_DIR ? !line : line),
    .i_analog_level(lvl), .o_speed_cmd(cmd), .o_run(run), .o_coast(coast),
    .o_preset_run(prun), .o_config_error(cerr));
  // clock and hang guard
  initial forever #12.5 i_clock = ~i_clock;
  always @(posedge i_clock) if (++cyc > 20000) begin
    err_total++;
    conclude();
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic chk_cmd(string n, logic signed [12:0] e);
    comparisons++;
    if (cmd !== e) begin
      err_total++;
      $display("mismatch %s exp %0d got %0d", n, e, cmd);
    end
  endtask : chk_cmd
  task automatic chk_bit(string n, logic e, logic g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s exp %b got %b", n, e, g);
    end
  endtask : chk_bit
  // lands on a falling edge so inputs change away from sampling
  task automatic wt(int n);
    repeat (n) @(posedge i_clock);
    @(negedge i_clock);
  endtask : wt
  task automatic t_analog;
    for (int k = 0; k < 4; k++) begin
      i_dir = k[0];
      lvl = k[1] ? 12'hfff : 12'h400;
      wt(2);
      chk_cmd("analog", k[0] ? $signed({1'b0, lvl}) : -$signed({1'b0, lvl}));
      chk_bit("run", 1, run);
    end
    lvl = '0;
    wt(2);
    chk_cmd("zero", 0);
  endtask : t_analog
  task automatic t_coast;
    lvl = 12'hfff;
    i_enable = 0;
    wt(2);
    chk_bit("coast", 1, coast && !run);
    chk_cmd("coast_cmd", 0);
    i_enable = 1;
  endtask : t_coast
  // waits of 320 cover one period plus the stale timeout
  task automatic t_pwm;
    i_method = mcid_pkg::MCID_PWM;
    i_dir = 1;
    hi = 16'h19;
    wt(320);
    chk_cmd("pwm25", 13'sd1023);
    i_dir = 0;
    hi = 16'h64;
    wt(320);
    chk_cmd("pwm100", -13'sd4095);
    hi = 16'h0;
    wt(320);
    chk_cmd("pwm0", 0);
  endtask : t_pwm
  task automatic t_dir;
    i_method = mcid_pkg::MCID_PWM_DIR;
    hi = 16'h64;
    wt(320);
    chk_cmd("dir100", 13'sd4095);
    hi = 16'h0;
    wt(320);
    chk_cmd("dir0", -13'sd4095);
    hi = 16'h32;
    wt(320);
    chk_bit("dir50", 1, cmd >= -13'sd1 && cmd <= 13'sd1);
  endtask : t_dir
  task automatic t_onoff;
    i_method = mcid_pkg::MCID_ON_OFF;
    i_mode = mcid_pkg::MCID_PRESET_SPEED;
    wt(2);
    chk_bit("prun", 1, prun && run && cmd == 0);
    i_mode = mcid_pkg::MCID_OPEN_SPEED;
    wt(2);
    chk_bit("cerr", 1, cerr && !run);
  endtask : t_onoff
  // main sequence
  initial begin
    wt(12);
    i_rst = 0;
    i_enable = 1;
    t_analog();
    t_coast();
    t_pwm();
    t_dir();
    t_onoff();
    conclude();
  end
endmodule : mcid_decoder_tb
`default_nettype wire
